// *** common/sso_defines.svh ***
// register offsets, field layouts, reset values and timing counts for the status output block
`ifndef SSO_DEFINES_SVH
`define SSO_DEFINES_SVH

`define SSO_OFF_MODE 12'h000
`define SSO_OFF_RELDLY 12'h004
`define SSO_OFF_ENGDLY 12'h008
`define SSO_OFF_CTRL 12'h00C
`define SSO_OFF_STATUS 12'h010
`define SSO_OFF_FAULTS 12'h014

// mode register: fault digit [1:0], brake digit [3:2], ready digit [5:4], servo-on digit [7:6]
`define SSO_MODE_FAULT_LSB 0
`define SSO_MODE_BRAKE_LSB 2
`define SSO_MODE_READY_LSB 4
`define SSO_MODE_SON_LSB 6
`define SSO_MODE_RESET 8'hFF

`define SSO_DIG_ACT_CLOSED 2'h1
`define SSO_DIG_ACT_OPEN 2'h2
`define SSO_DIG_OFF 2'h3

`define SSO_NUM_FAULTS 11

`define SSO_CLK_MHZ 250
// hold-up time after main power loss, in milliseconds
`define SSO_HOLDUP_MS 1000
`define SSO_HOLDUP_CYC (`SSO_HOLDUP_MS * 1000 * `SSO_CLK_MHZ + 1)

`define SSO_DLY_RESET 32'h0000_0000

`define SSO_RESP_OKAY 2'h0
`define SSO_RESP_SLVERR 2'h2

`endif

// *** common/sso_pkg.sv ***
// types for the status output block
package sso_pkg;
   typedef enum logic [1:0] {
      SSO_BRK_HOLD,
      SSO_BRK_RELEASING,
      SSO_BRK_FREE,
      SSO_BRK_ENGAGING
   } sso_brake_state_t;

   typedef struct packed {
      logic fault_indication_output;
      logic brake_control_output;
      logic ready_indication_output;
      logic servo_on_indication_output;
   } sso_outs_t;

   // fault sources, bit order as in the fault status register
   typedef struct packed {
      logic bad_hall;
      logic over_velocity;
      logic over_current;
      logic logic_error;
      logic safe_torque_off;
      logic internal_voltage;
      logic low_voltage;
      logic over_voltage;
      logic over_temperature;
      logic encoder_error;
      logic position_error;
   } sso_faults_t;
endpackage

// *** rtl/sso_status_out.sv ***
// status output logic: fault, brake, ready and servo-on outputs behind an AXI4-Lite slave
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`include "sso_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module sso_status_out (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // drive condition
   input wire sso_pkg::sso_faults_t fault_in,
   input wire logic main_power_ok,
   input wire logic motor_moving,
   // outputs: 1 = contact closed
   output logic drive_enable,
   output sso_pkg::sso_outs_t outs
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // contact level from a polarity digit: 1 closes on active, 2 opens on active
   function automatic logic contact(input logic [1:0] dig, input logic active, input logic gp);
      logic r;
      r = gp;
      if (dig == `SSO_DIG_ACT_CLOSED) begin
         r = active;
      end else if (dig == `SSO_DIG_ACT_OPEN) begin
         r = ~active;
      end
      return r;
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] mode_reg;
   logic [31:0] reldly_reg;
   logic [31:0] engdly_reg;
   logic [1:0] ctrl_reg;
   logic [3:0] gp_reg;
   logic [10:0] fault_latch_reg;
   logic lv_warn_reg;
   logic aw_held_reg, w_held_reg;
   logic [11:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic servo_on_reg;
   logic ready_reg;
   logic [31:0] holdup_reg;
   logic [31:0] brk_cnt_reg;
   sso_pkg::sso_brake_state_t brk_state_reg, brk_state_next;
   logic [31:0] brk_cnt_next;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire logic [1:0] dig_fault = mode_reg[`SSO_MODE_FAULT_LSB +: 2];
   wire logic [1:0] dig_brake = mode_reg[`SSO_MODE_BRAKE_LSB +: 2];
   wire logic [1:0] dig_ready = mode_reg[`SSO_MODE_READY_LSB +: 2];
   wire logic [1:0] dig_son = mode_reg[`SSO_MODE_SON_LSB +: 2];
   wire logic [10:0] fault_vec = fault_in;
   // power loss during servo-on adds low voltage, and position error if moving
   wire logic pwr_loss_son = servo_on_reg & ~main_power_ok;
   wire logic [10:0] fault_eff = fault_vec | {6'h00, pwr_loss_son, 3'h0,
                                              pwr_loss_son & motor_moving};
   wire logic [31:0] mode_merged = wmerge({24'h000000, mode_reg}, wdata_reg, wstrb_reg);
   wire logic any_fault = |fault_eff | (|fault_latch_reg);
   wire logic warning = any_fault | lv_warn_reg;
   wire logic son_req = ctrl_reg[0] & ~any_fault & main_power_ok;
   wire logic do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   wire logic [11:0] rd_addr = s_axi_araddr;
   wire logic rd_take = s_axi_arvalid & s_axi_arready;
   wire logic ready_cond = main_power_ok & ~any_fault;
   wire logic holdup_run = (holdup_reg != 32'h0);
   wire logic [31:0] holdup_dec = holdup_reg - 32'h1;
   wire logic brake_engaged = (brk_state_reg == sso_pkg::SSO_BRK_HOLD) |
                              (brk_state_reg == sso_pkg::SSO_BRK_RELEASING);
   wire logic map_w = (awaddr_reg == `SSO_OFF_MODE) | (awaddr_reg == `SSO_OFF_RELDLY) |
                      (awaddr_reg == `SSO_OFF_ENGDLY) | (awaddr_reg == `SSO_OFF_CTRL);
   logic [31:0] rd_mux;
   logic rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      unique case (rd_addr)
         `SSO_OFF_MODE: rd_mux = {24'h000000, mode_reg};
         `SSO_OFF_RELDLY: rd_mux = reldly_reg;
         `SSO_OFF_ENGDLY: rd_mux = engdly_reg;
         `SSO_OFF_CTRL: rd_mux = {26'h0000000, gp_reg, ctrl_reg};
         `SSO_OFF_STATUS: rd_mux = {24'h000000, lv_warn_reg, ready_reg, servo_on_reg,
                                    brake_engaged, outs};
         `SSO_OFF_FAULTS: rd_mux = {21'h000000, fault_latch_reg};
         default: begin
            rd_mux = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // axi4-lite slave: write answers one cycle after both halves held
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         awaddr_reg <= 12'h000;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SSO_RESP_OKAY;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_reg <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_reg <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_reg <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= map_w ? `SSO_RESP_OKAY : `SSO_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SSO_RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_arready <= 1'b0;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_ok ? `SSO_RESP_OKAY : `SSO_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // configuration: new settings act from the next edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= `SSO_MODE_RESET;
         reldly_reg <= `SSO_DLY_RESET;
         engdly_reg <= `SSO_DLY_RESET;
         ctrl_reg <= 2'h0;
         gp_reg <= 4'h0;
      end else if (do_write) begin
         if (awaddr_reg == `SSO_OFF_MODE) begin
            mode_reg <= mode_merged[7:0];
         end
         if (awaddr_reg == `SSO_OFF_RELDLY) begin
            reldly_reg <= wmerge(reldly_reg, wdata_reg, wstrb_reg);
         end
         if (awaddr_reg == `SSO_OFF_ENGDLY) begin
            engdly_reg <= wmerge(engdly_reg, wdata_reg, wstrb_reg);
         end
         if (awaddr_reg == `SSO_OFF_CTRL & wstrb_reg[0]) begin
            ctrl_reg <= wdata_reg[1:0];
            gp_reg <= wdata_reg[5:2];
         end
      end
   end

   // ----------------------------------------------------------------
   // fault latch and drive state
   // ----------------------------------------------------------------
   // latched faults clear by writing ctrl bit1; a fault present that cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_latch_reg <= 11'h000;
         servo_on_reg <= 1'b0;
         lv_warn_reg <= 1'b0;
      end else begin
         fault_latch_reg <= (ctrl_reg[1] ? 11'h000 : fault_latch_reg) | fault_eff;
         servo_on_reg <= son_req;
         lv_warn_reg <= ~main_power_ok;
      end
   end

   // with power present any fault drops ready at once; after loss of power it falls when the hold-up count runs out or a fault input appears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         holdup_reg <= 32'h0;
         ready_reg <= 1'b0;
      end else if (ready_cond) begin
         holdup_reg <= 32'(`SSO_HOLDUP_CYC);
         ready_reg <= 1'b1;
      end else if (~main_power_ok & ~(|fault_vec) & ready_reg & holdup_run) begin
         holdup_reg <= holdup_dec;
      end else begin
         holdup_reg <= 32'h0;
         ready_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // brake sequencing
   // ----------------------------------------------------------------
   always_comb begin
      brk_state_next = brk_state_reg;
      brk_cnt_next = brk_cnt_reg;
      unique case (brk_state_reg)
         sso_pkg::SSO_BRK_HOLD: begin
            if (son_req) begin
               brk_state_next = sso_pkg::SSO_BRK_RELEASING;
               brk_cnt_next = reldly_reg;
            end
         end
         sso_pkg::SSO_BRK_RELEASING: begin
            if (!son_req) begin
               brk_state_next = sso_pkg::SSO_BRK_HOLD;
            end else if (brk_cnt_reg == 32'h0) begin
               brk_state_next = sso_pkg::SSO_BRK_FREE;
            end else begin
               brk_cnt_next = brk_cnt_reg - 32'h1;
            end
         end
         sso_pkg::SSO_BRK_FREE: begin
            if (!son_req) begin
               brk_state_next = sso_pkg::SSO_BRK_ENGAGING;
               brk_cnt_next = engdly_reg;
            end
         end
         sso_pkg::SSO_BRK_ENGAGING: begin
            // hold only once the drive has been off for the engage delay
            // a new enable cancels the engage so the brake never closes on a driven shaft
            if (son_req) begin
               brk_state_next = sso_pkg::SSO_BRK_FREE;
            end else if (brk_cnt_reg == 32'h0) begin
               brk_state_next = sso_pkg::SSO_BRK_HOLD;
            end else begin
               brk_cnt_next = brk_cnt_reg - 32'h1;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         brk_state_reg <= sso_pkg::SSO_BRK_HOLD;
         brk_cnt_reg <= 32'h0;
      end else begin
         brk_state_reg <= brk_state_next;
         brk_cnt_reg <= brk_cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive_enable <= 1'b0;
         outs <= '0;
      end else begin
         drive_enable <= son_req;
         // digit 2 closes without warning; 3 keeps the line open
         outs.fault_indication_output <= (dig_fault == `SSO_DIG_OFF) ? 1'b0 :
                                         contact(dig_fault, warning, 1'b0);
         // digit 1 here opens the contact to engage the brake
         outs.brake_control_output <= (dig_brake == `SSO_DIG_OFF) ? gp_reg[1] :
                                      contact(~dig_brake, brake_engaged, 1'b0);
         outs.ready_indication_output <= contact(~dig_ready, ~ready_reg, gp_reg[2]);
         outs.servo_on_indication_output <= contact(dig_son, servo_on_reg, gp_reg[3]);
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_fault_disables: assert property (@(posedge aclk) disable iff (!aresetn)
      (|fault_vec) |=> !drive_enable) else $error("drive stays enabled on fault");
   chk_fault_latched: assert property (@(posedge aclk) disable iff (!aresetn)
      (|fault_vec) |=> (fault_latch_reg != 11'h000)) else $error("fault not latched");
   chk_fault_mode2: assert property (@(posedge aclk) disable iff (!aresetn)
      (dig_fault == 2'h2 && warning) |=> !outs.fault_indication_output)
      else $error("fault output closed under warning");
   chk_fault_mode1: assert property (@(posedge aclk) disable iff (!aresetn)
      (dig_fault == 2'h1 && warning) |=> outs.fault_indication_output)
      else $error("fault output open under warning");
   chk_fault_off: assert property (@(posedge aclk) disable iff (!aresetn)
      (dig_fault == 2'h3) |=> !outs.fault_indication_output)
      else $error("disabled fault output active");
   chk_brake_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (brk_state_reg == sso_pkg::SSO_BRK_HOLD && $past(brk_state_reg) ==
       sso_pkg::SSO_BRK_ENGAGING) |-> !drive_enable)
      else $error("brake engaged on running drive");
   chk_brake_gp: assert property (@(posedge aclk) disable iff (!aresetn)
      (dig_brake == 2'h3) |=> outs.brake_control_output == $past(gp_reg[1]))
      else $error("brake gp level wrong");
   chk_brake_contact: assert property (@(posedge aclk) disable iff (!aresetn)
      (dig_brake == 2'h2) |=> outs.brake_control_output == $past(brake_engaged))
      else $error("brake contact level wrong");
   chk_ready_nopower: assert property (@(posedge aclk) disable iff (!aresetn)
      (!main_power_ok && !ready_reg) |=> !ready_reg && lv_warn_reg)
      else $error("ready without power");
   chk_ready_mode1: assert property (@(posedge aclk) disable iff (!aresetn)
      (dig_ready == 2'h1) |=> outs.ready_indication_output == $past(ready_reg))
      else $error("ready output wrong");
   chk_ready_holdup: assert property (@(posedge aclk) disable iff (!aresetn)
      (ready_reg && !main_power_ok && !(|fault_vec) && holdup_run) |=> ready_reg)
      else $error("ready dropped during hold-up");
   chk_son_mode1: assert property (@(posedge aclk) disable iff (!aresetn)
      (dig_son == 2'h1) |=> outs.servo_on_indication_output == $past(servo_on_reg))
      else $error("servo-on output wrong");
   cov_fault: cover property (@(posedge aclk) disable iff (!aresetn)
      drive_enable ##1 (|fault_vec) ##1 !drive_enable);
   cov_brake_free: cover property (@(posedge aclk) disable iff (!aresetn)
      brk_state_reg == sso_pkg::SSO_BRK_FREE);
   cov_holdup: cover property (@(posedge aclk) disable iff (!aresetn)
      ready_reg && !main_power_ok);
endmodule
`default_nettype wire

// *** dv/sso_relay_model.sv ***
// brake relay and shaft model on the far side of the brake contact
`timescale 1ns/10ps
`default_nettype none
module sso_relay_model (
   // contact from the block
   input wire sso_pkg::sso_outs_t outs,
   // brake wiring chosen by software
   input wire logic [1:0] brake_digit,
   // shaft state
   output logic shaft_held
);
   // a closed contact energises the relay coil
   logic coil;
   assign coil = outs.brake_control_output;
   // other digits leave the brake unwired, so the shaft is never held by it
   assign shaft_held = (brake_digit == 2'h2) ? coil : (brake_digit == 2'h1) ? !coil : 1'b0;
endmodule
`default_nettype wire

// *** dv/servo_status_output_logic_tb.sv ***
// self-checking bench for the servo status output block
`include "sso_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module servo_status_output_logic_tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, brake_digit, rr;
   logic main_power_ok, motor_moving, drive_enable, shaft_held;
   sso_pkg::sso_faults_t fault_in;
   sso_pkg::sso_outs_t outs;
   int n_mismatch, checks_done;
   // short delays keep the brake sequence visible within a few dozen cycles
   localparam int REL_DLY = 20;
   localparam int ENG_DLY = 10;

   sso_status_out sso_status_out_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fault_in(fault_in),
      .main_power_ok(main_power_ok), .motor_moving(motor_moving),
      .drive_enable(drive_enable), .outs(outs));
   sso_relay_model sso_relay_model_inst (.outs(outs), .brake_digit(brake_digit),
      .shaft_held(shaft_held));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // ----------------------------------------
   // checking and bus tasks
   // ----------------------------------------
   task automatic final_report();
      $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic bound(input int n);
      if (n >= 200) begin
         n_mismatch++;
         $display("mismatch at %0t: wait timed out", $time);
         final_report();
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask

   function automatic logic [31:0] md(input logic [1:0] f, b, r, s);
      return {24'h0, s, r, b, f};
   endfunction

   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
      bit aw, w;
      int n;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 200 && !(aw && w); n++) begin
         @(posedge aclk);
         if (!aw && s_axi_awready) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      bound(n);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 200);
      bound(n);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [11:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 200);
      bound(n);
      s_axi_arvalid <= 1'b0;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 200);
      bound(n);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic clr_fault();
      fault_in <= '0;
      axi_wr(`SSO_OFF_CTRL, 32'h3);
      axi_wr(`SSO_OFF_CTRL, 32'h1);
      cyc(3);
   endtask

   // brake and drive enable must change apart by the programmed delay
   task automatic brk_seq(input logic [31:0] c, input int dly);
      int ce, cb, n;
      ce = -1;
      cb = -1;
      axi_wr(`SSO_OFF_CTRL, c);
      for (n = 0; n < 200 && (ce < 0 || cb < 0); n++) begin
         @(posedge aclk);
         if (ce < 0 && drive_enable === c[0]) ce = n;
         if (cb < 0 && shaft_held === !c[0]) cb = n;
      end
      bound(n);
      chk(32'((ce > cb ? ce - cb : cb - ce) >= dly - 3), 1, "brake delay spacing");
      chk(32'((ce > cb ? ce : cb) <= dly + 8), 1, "brake delay length");
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_and_bus();
      axi_rd(`SSO_OFF_MODE);
      chk(rd, 32'hFF, "mode reset");
      axi_rd(`SSO_OFF_RELDLY);
      chk(rd, 0, "release delay reset");
      chk(32'(outs), 0, "outputs after reset");
      axi_rd(12'h020);
      chk({30'h0, rr}, `SSO_RESP_SLVERR, "unmapped read");
      chk(rd, 0, "unmapped data");
      axi_wr(`SSO_OFF_STATUS, 32'hFFFF_FFFF);
      chk({30'h0, rr}, `SSO_RESP_SLVERR, "status write");
      axi_wr(`SSO_OFF_CTRL, 32'h08);
      cyc(2);
      chk(outs[2], 1, "general purpose brake contact");
   endtask

   task automatic t_ready_son();
      axi_wr(`SSO_OFF_MODE, md(3, 3, 1, 3));
      cyc(2);
      chk(outs[1], 0, "ready without power");
      axi_rd(`SSO_OFF_STATUS);
      chk(rd[7], 1, "low voltage warning");
      main_power_ok <= 1'b1;
      cyc(3);
      chk(outs[1], 1, "ready closed");
      axi_wr(`SSO_OFF_MODE, md(3, 3, 2, 3));
      cyc(2);
      chk(outs[1], 0, "ready inverted");
      axi_wr(`SSO_OFF_MODE, md(3, 3, 1, 1));
      axi_wr(`SSO_OFF_CTRL, 32'h1);
      cyc(3);
      chk(drive_enable, 1, "servo on");
      chk(outs[0], 1, "servo on contact");
      axi_wr(`SSO_OFF_MODE, md(3, 3, 1, 2));
      cyc(2);
      chk(outs[0], 0, "servo on inverted");
      axi_wr(`SSO_OFF_MODE, md(3, 3, 1, 3));
      axi_wr(`SSO_OFF_CTRL, 32'h21);
      cyc(2);
      chk(outs[0], 1, "servo on general purpose");
      axi_wr(`SSO_OFF_CTRL, 32'h1);
   endtask

   task automatic t_faults();
      axi_wr(`SSO_OFF_MODE, md(2, 3, 1, 3));
      cyc(2);
      chk(outs[3], 1, "fault contact idle");
      for (int i = 0; i < `SSO_NUM_FAULTS; i++) begin
         fault_in <= sso_pkg::sso_faults_t'(11'h1 << i);
         cyc(2);
         chk(drive_enable, 0, "drive off on fault");
         chk(outs[3], 0, "fault contact open");
         axi_rd(`SSO_OFF_FAULTS);
         chk({21'h0, rd[10:0]}, 32'h1 << i, "fault latched");
         clr_fault();
         chk(drive_enable, 1, "drive back after clear");
      end
      axi_wr(`SSO_OFF_MODE, md(1, 3, 1, 3));
      cyc(2);
      chk(outs[3], 0, "fault digit 1 idle");
      fault_in <= sso_pkg::sso_faults_t'(11'h8);
      cyc(2);
      chk(outs[3], 1, "fault digit 1 active");
      clr_fault();
      axi_wr(`SSO_OFF_MODE, md(3, 3, 1, 3));
      fault_in <= sso_pkg::sso_faults_t'(11'h10);
      cyc(2);
      chk(outs[3], 0, "fault output off");
      clr_fault();
   endtask

   task automatic t_brake();
      axi_wr(`SSO_OFF_RELDLY, REL_DLY);
      axi_wr(`SSO_OFF_ENGDLY, ENG_DLY);
      axi_wr(`SSO_OFF_CTRL, 32'h0);
      axi_wr(`SSO_OFF_MODE, md(3, 2, 1, 3));
      brake_digit <= 2'h2;
      cyc(ENG_DLY + 4);
      chk(outs[2], 1, "brake closed engages");
      brk_seq(32'h1, REL_DLY);
      brk_seq(32'h0, ENG_DLY);
      axi_wr(`SSO_OFF_MODE, md(3, 1, 1, 3));
      brake_digit <= 2'h1;
      cyc(2);
      chk(outs[2], 0, "brake digit 1 inverts");
      chk(shaft_held, 1, "shaft held while disabled");
   endtask

   task automatic t_power_loss();
      main_power_ok <= 1'b0;
      cyc(500);
      chk(outs[1], 1, "ready holds after power loss");
      aresetn <= 1'b0;
      main_power_ok <= 1'b1;
      cyc(2);
      aresetn <= 1'b1;
      cyc(1);
      axi_wr(`SSO_OFF_CTRL, 32'h1);
      motor_moving <= 1'b1;
      cyc(3);
      chk(drive_enable, 1, "servo on before loss");
      main_power_ok <= 1'b0;
      cyc(4);
      chk(drive_enable, 0, "drive off on power loss");
      axi_rd(`SSO_OFF_FAULTS);
      chk({rd[4], rd[0]}, 2'h3, "low voltage and position faults");
      axi_rd(`SSO_OFF_STATUS);
      chk(rd[7], 1, "voltage warning");
   endtask

   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hF;
      fault_in = '0;
      main_power_ok = 1'b0;
      motor_moving = 1'b0;
      brake_digit = 2'h3;
      n_mismatch = 0;
      checks_done = 0;
      cyc(12);
      aresetn <= 1'b1;
      cyc(1);
      t_reset_and_bus();
      t_ready_son();
      t_faults();
      t_brake();
      t_power_loss();
      final_report();
   end
endmodule
`default_nettype wire
